/* File: tb/fcds_bus_partner.sv */
`timescale 1ns/1ps

module fcds_bus_partner (
   input wire core_clk,
   input wire reset,
   input wire busReq,
   input wire memReq,
   input wire logic [3:0] gntDly,
   input wire logic [3:0] memDly,
   output logic busGrant,
   output logic memDone
);
   logic [3:0] gntCnt;
   logic [3:0] memCnt;
   // grant after gntDly cycles, held while asked
   always_ff @(posedge core_clk) begin
      if (reset || !busReq) begin
         gntCnt <= 4'h0;
         busGrant <= 1'b0;
      end else if (gntCnt >= gntDly) begin
         busGrant <= 1'b1;
      end else begin
         gntCnt <= gntCnt + 4'h1;
      end
   end
   // one-cycle completion after memDly cycles of request
   always_ff @(posedge core_clk) begin
      if (reset || !memReq || memDone) begin
         memCnt <= 4'h0;
         memDone <= 1'b0;
      end else if (memCnt >= memDly) begin
         memDone <= 1'b1;
      end else begin
         memCnt <= memCnt + 4'h1;
      end
   end
endmodule

/* File: tb/test_four_channel_dma_sequencer.sv */
`timescale 1ns/1ps

module test_four_channel_dma_sequencer;
   import fcds_pkg::*;
   logic core_clk;
   logic reset;
   fcds_mask_t chanReq;
   fcds_mask_t chanAck;
   logic busReq, busGrant, memReq, memDone, addrWrEn, busy, busLow;
   fcds_cnt_t memAddr;
   fcds_bank_t memBank;
   fcds_chan_t addrWrChan, rdChan, activeChan;
   fcds_addr_t addrWrData, rdAddr;
   logic [3:0] gntDly, memDly;
   int n_errors, comparisons;
   int cycles = 0;

   fcds_dma_sequencer uut (.core_clk(core_clk), .reset(reset), .chanReq(chanReq),
      .chanAck(chanAck), .busReq(busReq), .busGrant(busGrant), .memReq(memReq),
      .memDone(memDone), .memAddr(memAddr), .memBank(memBank), .addrWrEn(addrWrEn),
      .addrWrChan(addrWrChan), .addrWrData(addrWrData), .rdChan(rdChan),
      .rdAddr(rdAddr), .busy(busy), .activeChan(activeChan));
   fcds_bus_partner partner (.core_clk(core_clk), .reset(reset), .busReq(busReq),
      .memReq(memReq), .gntDly(gntDly), .memDly(memDly), .busGrant(busGrant),
      .memDone(memDone));

   task automatic cmp(input logic [23:0] got, input logic [23:0] exp, input string what);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic final_report;
      if (n_errors == 0 && comparisons > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   function automatic fcds_addr_t pval(input int i);
      return {2'(i), 22'h155550 + 22'(i)};
   endfunction

   task automatic load(input fcds_chan_t c, input fcds_addr_t d);
      @(posedge core_clk);
      addrWrEn <= 1'b1;
      addrWrChan <= c;
      addrWrData <= d;
      @(posedge core_clk);
      addrWrEn <= 1'b0;
   endtask

   task automatic readback(input fcds_chan_t c, input fcds_addr_t exp);
      @(posedge core_clk);
      rdChan <= c;
      repeat (2) @(posedge core_clk);
      #1 cmp(rdAddr, exp, "rdAddr");
   endtask

   // waits for completion, then checks ack, address, bank and channel
   task automatic wait_ack(input int k, input fcds_addr_t a);
      int n;
      n = 0;
      busLow = 1'b0;
      do begin
         @(posedge core_clk);
         #1;
         n++;
         if (busReq !== 1'b1) busLow = 1'b1;
      end while (memDone !== 1'b1 && n < 40);
      cmp({23'h0, memReq}, 24'h1, "memReq");
      cmp({20'h0, chanAck}, 24'(1 << k), "chanAck");
      cmp({2'h0, memAddr}, {2'h0, a[21:0]}, "memAddr");
      cmp({22'h0, memBank}, {22'h0, a[23:22]}, "memBank");
      cmp({22'h0, activeChan}, 24'(k), "activeChan");
   endtask

   task automatic t_single;
      @(posedge core_clk);
      gntDly <= 4'h3;
      memDly <= 4'h2;
      load(2'h2, 24'hBFFFFF);
      readback(2'h2, 24'hBFFFFF);
      cmp({23'h0, busReq}, 24'h0, "busReq idle");
      @(posedge core_clk);
      chanReq <= 4'h4;
      wait_ack(2, 24'hBFFFFF);
      @(posedge core_clk);
      chanReq <= 4'h0;
      repeat (4) @(posedge core_clk);
      #1 cmp({22'h0, busReq, busy}, 24'h0, "busReq after");
      readback(2'h2, 24'h800000);
   endtask

   task automatic t_priority;
      int i;
      @(posedge core_clk);
      gntDly <= 4'h0;
      memDly <= 4'h0;
      for (i = 0; i < 4; i++) load(2'(i), pval(i));
      @(posedge core_clk);
      chanReq <= 4'hF;
      for (i = 0; i < 4; i++) begin
         wait_ack(i, pval(i));
         @(posedge core_clk);
         chanReq <= chanReq & ~(4'h1 << i);
      end
      for (i = 0; i < 4; i++) readback(2'(i), pval(i) + 24'h1);
   endtask

   task automatic t_repeat;
      @(posedge core_clk);
      gntDly <= 4'h1;
      memDly <= 4'h3;
      load(2'h1, 24'h123456);
      @(posedge core_clk);
      chanReq <= 4'h2;
      wait_ack(1, 24'h123456);
      wait_ack(1, 24'h123457);
      cmp({23'h0, busLow}, 24'h0, "bus released in repeat");
      @(posedge core_clk);
      chanReq <= 4'h0;
      repeat (4) @(posedge core_clk);
      readback(2'h1, 24'h123458);
   endtask

   // reset in mid-access, then a full service from the cleared state
   task automatic t_reset;
      @(posedge core_clk);
      gntDly <= 4'h0;
      memDly <= 4'h8;
      load(2'h3, 24'h4ABCDE);
      @(posedge core_clk);
      chanReq <= 4'h8;
      repeat (6) @(posedge core_clk);
      reset <= 1'b1;
      chanReq <= 4'h0;
      repeat (2) @(posedge core_clk);
      reset <= 1'b0;
      #1 cmp({20'h0, busReq, memReq, activeChan}, 24'h0, "state after reset");
      cmp({2'h0, memAddr}, 24'h0, "memAddr after reset");
      readback(2'h3, 24'h000000);
      load(2'h3, 24'h4ABCDE);
      @(posedge core_clk);
      chanReq <= 4'h8;
      wait_ack(3, 24'h4ABCDE);
      @(posedge core_clk);
      chanReq <= 4'h0;
      repeat (4) @(posedge core_clk);
      readback(2'h3, 24'h4ABCDF);
   endtask

   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end

   initial begin
      reset = 1'b1;
      chanReq = 4'h0;
      addrWrEn = 1'b0;
      addrWrChan = 2'h0;
      addrWrData = 24'h000000;
      rdChan = 2'h0;
      gntDly = 4'h0;
      memDly = 4'h0;
      n_errors = 0;
      comparisons = 0;
      repeat (16) @(posedge core_clk);
      reset <= 1'b0;
      readback(2'h3, 24'h000000);
      t_single();
      t_priority();
      t_repeat();
      t_reset();
      final_report();
   end

   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 3000) begin
         n_errors++;
         $display("mismatch %0t timeout", $time);
         final_report();
      end
   end
endmodule

/* File: verilog/fcds_dma_sequencer.sv */
`timescale 1ns/1ps
`include "fcds_params.svh"


module fcds_dma_sequencer (
   input wire core_clk,
   input wire reset,
   input wire fcds_pkg::fcds_mask_t chanReq,
   output fcds_pkg::fcds_mask_t chanAck,
   output logic busReq,
   input wire busGrant,
   output logic memReq,
   input wire memDone,
   output fcds_pkg::fcds_cnt_t memAddr,
   output fcds_pkg::fcds_bank_t memBank,
   input wire addrWrEn,
   input wire fcds_pkg::fcds_chan_t addrWrChan,
   input wire fcds_pkg::fcds_addr_t addrWrData,
   input wire fcds_pkg::fcds_chan_t rdChan,
   output fcds_pkg::fcds_addr_t rdAddr,
   output logic busy,
   output fcds_pkg::fcds_chan_t activeChan
);
   import fcds_pkg::*;

   fcds_state_t cur_ff;
   fcds_state_t nxt_ff;

   fcds_mask_t arbOneHot;
   fcds_chan_t arbIdx;
   logic arbAny;
   fcds_mask_t selOneHot;
   fcds_mask_t wbHit;
   fcds_mask_t cpuHit;
   logic inAccess;
   logic selStillReq;

   fcds_prio_arbiter u_arb (
      .req(chanReq),
      .grantOneHot(arbOneHot),
      .grantIdx(arbIdx),
      .anyReq(arbAny)
   );

   // per-channel write strobes for the address registers
   genvar gi;
   generate
      for (gi = 0; gi < `FCDS_NUM_CHAN; gi = gi + 1) begin : g_chan
         assign selOneHot[gi] = (cur_ff.sel == fcds_chan_t'(gi));
         assign wbHit[gi] = selOneHot[gi] && (cur_ff.seq == ADDRESS_WRITEBACK_STATE);
         assign cpuHit[gi] = addrWrEn && (addrWrChan == fcds_chan_t'(gi));
      end
   endgenerate

   assign inAccess = (cur_ff.seq == MEMORY_ACCESS_STATE) ||
                     (cur_ff.seq == REPEAT_ACCESS_STATE);
   assign selStillReq = chanReq[cur_ff.sel];

   always_comb begin
      nxt_ff = cur_ff;
      nxt_ff.rdAddr = cur_ff.chanAddr[rdChan];
      for (int i = 0; i < `FCDS_NUM_CHAN; i = i + 1) begin
         // write-back beats a simultaneous processor load
         if (wbHit[i]) begin
            nxt_ff.chanAddr[i] = {cur_ff.bank, cur_ff.cnt};
         end else if (cpuHit[i]) begin
            nxt_ff.chanAddr[i] = addrWrData;
         end
      end
      case (cur_ff.seq)
         IDLE_WAIT_REQUEST: begin
            if (arbAny) begin
               nxt_ff.sel = arbIdx;
               nxt_ff.seq = BUS_REQUEST_WAIT;
            end
         end
         BUS_REQUEST_WAIT: begin
            if (busGrant) begin
               nxt_ff.cnt = cur_ff.chanAddr[cur_ff.sel][`FCDS_CNT_MSB:0];
               nxt_ff.bank = cur_ff.chanAddr[cur_ff.sel][`FCDS_BANK_MSB:`FCDS_BANK_LSB];
               nxt_ff.seq = MEMORY_ACCESS_STATE;
            end
         end
         MEMORY_ACCESS_STATE: begin
            if (memDone) begin
               nxt_ff.seq = ADDRESS_INCREMENT_STATE;
            end
         end
         ADDRESS_INCREMENT_STATE: begin
            nxt_ff.cnt = cur_ff.cnt + `FCDS_CNT_STEP;
            nxt_ff.seq = ADDRESS_WRITEBACK_STATE;
         end
         ADDRESS_WRITEBACK_STATE: begin
            if (selStillReq) begin
               nxt_ff.seq = REPEAT_ACCESS_STATE;
            end else begin
               nxt_ff.seq = IDLE_WAIT_REQUEST;
            end
         end
         REPEAT_ACCESS_STATE: begin
            if (memDone) begin
               nxt_ff.seq = ADDRESS_INCREMENT_STATE;
            end
         end
         default: begin
            nxt_ff.seq = IDLE_WAIT_REQUEST;
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         cur_ff.seq <= IDLE_WAIT_REQUEST;
         cur_ff.sel <= `FCDS_CHAN_RST;
         cur_ff.cnt <= `FCDS_CNT_RST;
         cur_ff.bank <= `FCDS_BANK_RST;
         for (int i = 0; i < `FCDS_NUM_CHAN; i = i + 1) begin
            cur_ff.chanAddr[i] <= `FCDS_ADDR_RST;
         end
         cur_ff.rdAddr <= `FCDS_ADDR_RST;
      end else begin
         cur_ff <= nxt_ff;
      end
   end

   // bus is held from the request until the channel is released
   assign busReq = (cur_ff.seq != IDLE_WAIT_REQUEST);
   assign memReq = inAccess;
   assign chanAck = (inAccess && memDone) ? selOneHot : 4'h0;
   assign memAddr = cur_ff.cnt;
   assign memBank = cur_ff.bank;
   assign rdAddr = cur_ff.rdAddr;
   assign busy = busReq;
   assign activeChan = cur_ff.sel;

   a_idle_stays: assert property (@(posedge core_clk) disable iff (reset)
      (cur_ff.seq == IDLE_WAIT_REQUEST && chanReq == 4'h0)
      |=> (cur_ff.seq == IDLE_WAIT_REQUEST && !busReq && !memReq))
      else $error("idle left without a request");

   a_req_to_bus: assert property (@(posedge core_clk) disable iff (reset)
      (cur_ff.seq == IDLE_WAIT_REQUEST && chanReq != 4'h0)
      |=> (cur_ff.seq == BUS_REQUEST_WAIT && busReq))
      else $error("request did not raise bus request");

   a_bus_wait_hold: assert property (@(posedge core_clk) disable iff (reset)
      (cur_ff.seq == BUS_REQUEST_WAIT && !busGrant)
      |=> (cur_ff.seq == BUS_REQUEST_WAIT && busReq && !memReq))
      else $error("bus wait left without grant");

   a_grant_loads: assert property (@(posedge core_clk) disable iff (reset)
      (cur_ff.seq == BUS_REQUEST_WAIT && busGrant)
      |=> (cur_ff.seq == MEMORY_ACCESS_STATE && memReq &&
           memAddr == $past(cur_ff.chanAddr[cur_ff.sel][`FCDS_CNT_MSB:0]) &&
           memBank == $past(cur_ff.chanAddr[cur_ff.sel][`FCDS_BANK_MSB:`FCDS_BANK_LSB])))
      else $error("counter not loaded from channel on grant");

   a_access_hold: assert property (@(posedge core_clk) disable iff (reset)
      (inAccess && !memDone) |=> (inAccess && memReq && $stable(memAddr)))
      else $error("memory access dropped before completion");

   a_done_acks: assert property (@(posedge core_clk) disable iff (reset)
      (inAccess && memDone)
      |-> (chanAck[cur_ff.sel] && $onehot(chanAck))
          ##1 (cur_ff.seq == ADDRESS_INCREMENT_STATE && chanAck == 4'h0))
      else $error("completion not acknowledged to owner");

   a_ack_only_done: assert property (@(posedge core_clk) disable iff (reset)
      (chanAck != 4'h0) |-> (memDone && memReq && $onehot(chanAck)))
      else $error("acknowledge without completion");

   a_incr_by_one: assert property (@(posedge core_clk) disable iff (reset)
      (cur_ff.seq == ADDRESS_INCREMENT_STATE)
      |=> (cur_ff.seq == ADDRESS_WRITEBACK_STATE &&
           memAddr == $past(memAddr) + `FCDS_CNT_STEP && $stable(memBank)))
      else $error("counter not incremented by one");

   a_wb_stores: assert property (@(posedge core_clk) disable iff (reset)
      (cur_ff.seq == ADDRESS_WRITEBACK_STATE)
      |=> (cur_ff.chanAddr[$past(cur_ff.sel)] == $past({cur_ff.bank, cur_ff.cnt})))
      else $error("write-back did not store counter");

   a_wb_to_idle: assert property (@(posedge core_clk) disable iff (reset)
      (cur_ff.seq == ADDRESS_WRITEBACK_STATE && !chanReq[cur_ff.sel])
      |=> (cur_ff.seq == IDLE_WAIT_REQUEST && !busReq))
      else $error("write-back did not return to idle");

   a_wb_repeat: assert property (@(posedge core_clk) disable iff (reset)
      (cur_ff.seq == ADDRESS_WRITEBACK_STATE && chanReq[cur_ff.sel])
      |=> (cur_ff.seq == REPEAT_ACCESS_STATE && busReq && memReq && $stable(activeChan)))
      else $error("repeat request did not reuse the bus");

   a_sel_stable: assert property (@(posedge core_clk) disable iff (reset)
      (cur_ff.seq != IDLE_WAIT_REQUEST) |=> (cur_ff.seq == IDLE_WAIT_REQUEST || $stable(cur_ff.sel)))
      else $error("serviced channel changed mid-service");

   a_prio_pick: assert property (@(posedge core_clk) disable iff (reset)
      (cur_ff.seq == IDLE_WAIT_REQUEST && chanReq[0]) |=> (activeChan == 2'h0))
      else $error("channel zero not preferred");

   a_cpu_load: assert property (@(posedge core_clk) disable iff (reset)
      (addrWrEn && !wbHit[addrWrChan])
      |=> (cur_ff.chanAddr[$past(addrWrChan)] == $past(addrWrData)))
      else $error("processor address load lost");

   // order of states, reset values and per-channel ownership
   a_reset_clears: assert property (@(posedge core_clk)
      reset
      |=> (cur_ff.seq == IDLE_WAIT_REQUEST && !busReq && !memReq && chanAck == 4'h0 &&
           memAddr == `FCDS_CNT_RST && memBank == `FCDS_BANK_RST &&
           activeChan == `FCDS_CHAN_RST))
      else $error("reset did not return the sequencer to idle");

   a_reset_regs: assert property (@(posedge core_clk)
      reset
      |=> (cur_ff.chanAddr == '0 && rdAddr == `FCDS_ADDR_RST))
      else $error("reset did not clear the channel addresses");

   a_idle_quiet: assert property (@(posedge core_clk) disable iff (reset)
      (cur_ff.seq == IDLE_WAIT_REQUEST) |-> (!busReq && !memReq && chanAck == 4'h0))
      else $error("idle drives the bus or memory");

   a_bus_from_idle: assert property (@(posedge core_clk) disable iff (reset)
      (cur_ff.seq == BUS_REQUEST_WAIT)
      |-> ($past(cur_ff.seq) == BUS_REQUEST_WAIT ||
           ($past(cur_ff.seq) == IDLE_WAIT_REQUEST && $past(chanReq) != 4'h0)))
      else $error("bus wait entered without a request");

   a_mem_needs_bus: assert property (@(posedge core_clk) disable iff (reset)
      memReq |-> busReq)
      else $error("memory requested without the bus");

   a_access_from_grant: assert property (@(posedge core_clk) disable iff (reset)
      (cur_ff.seq == MEMORY_ACCESS_STATE)
      |-> ($past(cur_ff.seq) == MEMORY_ACCESS_STATE ||
           ($past(cur_ff.seq) == BUS_REQUEST_WAIT && $past(busGrant))))
      else $error("memory access entered without a grant");

   a_wait_keeps_state: assert property (@(posedge core_clk) disable iff (reset)
      (inAccess && !memDone) |=> $stable(cur_ff.seq))
      else $error("access state left before completion");

   a_inc_after_done: assert property (@(posedge core_clk) disable iff (reset)
      (cur_ff.seq == ADDRESS_INCREMENT_STATE) |-> ($past(inAccess) && $past(memDone)))
      else $error("increment without a completed transfer");

   a_cnt_hold: assert property (@(posedge core_clk) disable iff (reset)
      (cur_ff.seq != BUS_REQUEST_WAIT && cur_ff.seq != ADDRESS_INCREMENT_STATE)
      |=> $stable(memAddr))
      else $error("counter moved outside load or increment");

   a_bank_hold: assert property (@(posedge core_clk) disable iff (reset)
      (cur_ff.seq != BUS_REQUEST_WAIT) |=> $stable(memBank))
      else $error("bank select moved outside the grant");

   a_wb_after_inc: assert property (@(posedge core_clk) disable iff (reset)
      (cur_ff.seq == ADDRESS_WRITEBACK_STATE)
      |-> ($past(cur_ff.seq) == ADDRESS_INCREMENT_STATE))
      else $error("write-back not preceded by increment");

   a_repeat_no_bus: assert property (@(posedge core_clk) disable iff (reset)
      (cur_ff.seq == REPEAT_ACCESS_STATE)
      |-> ($past(cur_ff.seq) == ADDRESS_WRITEBACK_STATE ||
           $past(cur_ff.seq) == REPEAT_ACCESS_STATE))
      else $error("repeat access entered from the wrong state");

   a_repeat_next_addr: assert property (@(posedge core_clk) disable iff (reset)
      (cur_ff.seq == ADDRESS_WRITEBACK_STATE && selStillReq)
      |=> ($stable(memAddr) && $stable(memBank)))
      else $error("repeat did not reuse the incremented counter");

   generate
      for (gi = 0; gi < `FCDS_NUM_CHAN; gi = gi + 1) begin : g_chan_chk
         a_ack_owner: assert property (@(posedge core_clk) disable iff (reset)
            chanAck[gi] |-> (activeChan == fcds_chan_t'(gi) && busReq))
            else $error("acknowledge sent to a channel not in service");

         a_ack_pulse: assert property (@(posedge core_clk) disable iff (reset)
            chanAck[gi] |=> !chanAck[gi])
            else $error("acknowledge longer than one cycle");

         a_addr_keep: assert property (@(posedge core_clk) disable iff (reset)
            (!wbHit[gi] && !cpuHit[gi]) |=> $stable(cur_ff.chanAddr[gi]))
            else $error("channel address changed without a load");

         a_own_prio: assert property (@(posedge core_clk) disable iff (reset)
            (cur_ff.seq == IDLE_WAIT_REQUEST && chanReq[gi] &&
             (chanReq & ~(4'hF << gi)) == 4'h0)
            |=> (activeChan == fcds_chan_t'(gi)))
            else $error("highest-priority request not taken");
      end
   endgenerate

endmodule

/* File: verilog/fcds_params.svh */
`ifndef FCDS_PARAMS_SVH
`define FCDS_PARAMS_SVH

// channel count and address layout
`define FCDS_NUM_CHAN 4
`define FCDS_CHAN_W 2
`define FCDS_ADDR_W 24
`define FCDS_CNT_W 22
`define FCDS_BANK_W 2
`define FCDS_BANK_LSB 22
`define FCDS_BANK_MSB 23
`define FCDS_CNT_MSB 21

// reset values and counter step
`define FCDS_ADDR_RST 24'h000000
`define FCDS_CNT_RST 22'h000000
`define FCDS_BANK_RST 2'h0
`define FCDS_CHAN_RST 2'h0
`define FCDS_CNT_STEP 22'h000001

`endif

/* File: verilog/fcds_pkg.sv */
`include "fcds_params.svh"

package fcds_pkg;

   typedef enum logic [2:0] {
      IDLE_WAIT_REQUEST,
      BUS_REQUEST_WAIT,
      MEMORY_ACCESS_STATE,
      ADDRESS_INCREMENT_STATE,
      ADDRESS_WRITEBACK_STATE,
      REPEAT_ACCESS_STATE
   } fcds_seq_t;

   typedef logic [`FCDS_ADDR_W-1:0] fcds_addr_t;
   typedef logic [`FCDS_CHAN_W-1:0] fcds_chan_t;
   typedef logic [`FCDS_NUM_CHAN-1:0] fcds_mask_t;
   typedef logic [`FCDS_CNT_W-1:0] fcds_cnt_t;
   typedef logic [`FCDS_BANK_W-1:0] fcds_bank_t;

   typedef struct packed {
      fcds_seq_t seq;
      fcds_chan_t sel;
      fcds_cnt_t cnt;
      fcds_bank_t bank;
      logic [`FCDS_NUM_CHAN-1:0][`FCDS_ADDR_W-1:0] chanAddr;
      fcds_addr_t rdAddr;
   } fcds_state_t;

endpackage

/* File: verilog/fcds_prio_arbiter.sv */
`timescale 1ns/1ps
`include "fcds_params.svh"

module fcds_prio_arbiter (
   input wire fcds_pkg::fcds_mask_t req,
   output fcds_pkg::fcds_mask_t grantOneHot,
   output fcds_pkg::fcds_chan_t grantIdx,
   output logic anyReq
);
   import fcds_pkg::*;

   // channel 0 wins, each lower channel masks all above it
   genvar gi;
   generate
      for (gi = 0; gi < `FCDS_NUM_CHAN; gi = gi + 1) begin : g_prio
         if (gi == 0) begin : g_top
            assign grantOneHot[gi] = req[gi];
         end else begin : g_rest
            assign grantOneHot[gi] = req[gi] & ~(|req[gi-1:0]);
         end
      end
   endgenerate

   assign grantIdx = {grantOneHot[3] | grantOneHot[2], grantOneHot[3] | grantOneHot[1]};
   assign anyReq = |req;

   always_comb begin
      a_grant_onehot: assert final ($onehot0(grantOneHot))
         else $error("arbiter granted more than one channel");
      a_grant_prio: assert final (!req[0] || grantIdx == 2'h0)
         else $error("channel zero request not preferred");
   end

endmodule
